// ### hdl/fcsc_core.sv
// Command status, error status and clock divider registers on APB
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "fcsc_defines.svh"
module fcsc_core
  import fcsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        seq_violation,
  input  wire logic        illegal_cmd,
  input  wire logic        protect_hit,
  input  wire logic        seq_start,
  input  wire logic        cmd_done,
  input  wire logic        cmd_abort,
  input  wire logic [1:0]  completion_status_field_err,
  input  wire logic        reset_seq_err,
  input  wire logic        ecc_single,
  input  wire logic        ecc_double,
  output logic             cmd_launch,
  output logic             seq_allowed,
  output logic             div_tick,
  output logic             irq
);

  fcsc_bus_t    bus;
  fcsc_result_t res;
  fcsc_state_t  state_ff, nxt_state;

  logic       command_complete_flag_ff, nxt_command_complete_flag;
  logic       access_error_flag_ff, nxt_access_error_flag;
  logic       pviol_ff, nxt_pviol;
  logic [1:0] completion_status_field_ff, nxt_completion_status_field;
  logic [5:0] div_ff, nxt_div;
  logic       divld_ff, nxt_divld;
  logic       divlck_ff, nxt_divlck;
  logic [1:0] errstat_ff, nxt_errstat;
  logic [3:0] mask_ff, nxt_mask;
  logic       lckmode_ff, nxt_lckmode;
  logic [3:0] irqstat_ff, nxt_irqstat;
  logic [5:0] pre_ff, nxt_pre;
  logic       tick_ff, nxt_tick;
  logic       launch_ff, nxt_launch;
  logic [31:0] rdata_ff, nxt_rdata;

  // Register map, one 32-bit word each, data in bits 7:0
  //   0x000 status: completion, access error, protection violation,
  //         busy, reserved zero, two completion status bits
  //   0x004 divider: loaded, locked, six-bit value
  //   0x008 error status: double and single fault, write one to clear
  //   0x00c interrupt mask: done, access error, protection, status error
  //   0x010 control: lock override mode in bit 0, interrupt status in 7:4
  // Unmapped offsets answer with an error and read zero.

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // Sticky flag update; the set side wins over a same-cycle clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  assign bus = '{addr: paddr, write: pwrite, wdata: pwdata, access: psel & penable};
  assign res = '{done: cmd_done, viol: cmd_abort, completion_status_field: completion_status_field_err};

  wire wr        = bus.access & bus.write;
  wire sel_stat  = hit(bus.addr, `FCSC_OFF_STATUS);
  wire sel_div   = hit(bus.addr, `FCSC_OFF_CLKDIV);
  wire sel_err   = hit(bus.addr, `FCSC_OFF_ERRSTAT);
  wire sel_mask  = hit(bus.addr, `FCSC_OFF_IRQMASK);
  wire sel_ctl   = hit(bus.addr, `FCSC_OFF_CMDCTL);
  wire mapped    = sel_stat | sel_div | sel_err | sel_mask | sel_ctl;
  wire wr_stat   = wr & sel_stat;
  wire wr_div    = wr & sel_div;
  wire wr_err    = wr & sel_err;
  wire wr_mask   = wr & sel_mask;
  wire wr_ctl    = wr & sel_ctl;
  wire w_command_complete_flag    = wr_stat & bus.wdata[`FCSC_BIT_COMMAND_COMPLETE_FLAG];
  wire w_access_error_flag  = wr_stat & bus.wdata[`FCSC_BIT_ACCESS_ERROR_FLAG];
  wire w_pviol   = wr_stat & bus.wdata[`FCSC_BIT_PVIOL];
  wire busy      = (state_ff == FCSC_RUN);
  // Launch refused while either error flag stands
  wire launch_ok = w_command_complete_flag & command_complete_flag_ff & ~access_error_flag_ff & ~pviol_ff;
  wire acc_set   = seq_violation | illegal_cmd;
  wire finish    = busy & (res.done | res.viol);
  wire lock_now  = wr_div & bus.wdata[`FCSC_BIT_DIVLCK] & ~divlck_ff;
  // Read data is taken in the setup cycle, so it stands through access
  wire rd_capture = psel & ~penable & ~pwrite;

  wire [1:0]  err_set  = {ecc_double, ecc_single};
  wire [1:0]  err_clr  = {2{wr_err}} & bus.wdata[1:0];
  wire [3:0]  irq_set  = {reset_seq_err | (finish & |res.completion_status_field), protect_hit, acc_set, finish};
  wire [3:0]  irq_clr  = {4{wr_ctl}} & bus.wdata[7:4];
  wire [1:0]  err_upd;
  wire [3:0]  irq_upd;

  wire [31:0] rd_div   = {24'h000000, divld_ff, divlck_ff, div_ff};
  wire [31:0] rd_err   = {30'h00000000, errstat_ff};
  wire [31:0] rd_mask  = {28'h0000000, mask_ff};
  wire [31:0] rd_ctl   = {24'h000000, irqstat_ff, 3'h0, lckmode_ff};

  genvar gi;
  generate
    // Error status bits: writes can only clear them
    for (gi = 0; gi < 2; gi++) begin : g_err
      assign err_upd[gi] = sticky(errstat_ff[gi], err_set[gi], err_clr[gi]);
    end
    // Interrupt status bits, one per event source
    for (gi = 0; gi < 4; gi++) begin : g_irq
      assign irq_upd[gi] = sticky(irqstat_ff[gi], irq_set[gi], irq_clr[gi]);
    end
  endgenerate

  assign pready      = 1'b1;
  assign pslverr     = bus.access & ~mapped;
  assign prdata      = rdata_ff;
  assign cmd_launch  = launch_ff;
  assign div_tick    = tick_ff;
  assign seq_allowed = command_complete_flag_ff & ~pviol_ff & ~access_error_flag_ff;
  assign irq         = |(irqstat_ff & mask_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FCSC_IDLE: if (launch_ok) nxt_state = FCSC_RUN;
      FCSC_RUN:  if (finish) nxt_state = FCSC_DONE;
      FCSC_DONE: nxt_state = FCSC_IDLE;
      default:   nxt_state = FCSC_IDLE;
    endcase
  end

  always_comb begin
    nxt_launch = launch_ok;
    nxt_command_complete_flag   = command_complete_flag_ff;
    if (launch_ok) nxt_command_complete_flag = 1'b0;
    if (finish) nxt_command_complete_flag = 1'b1;
    // Set wins over the same-cycle clear
    nxt_access_error_flag = sticky(access_error_flag_ff, acc_set, w_access_error_flag);
    nxt_pviol  = sticky(pviol_ff, protect_hit, w_pviol);
    nxt_completion_status_field = completion_status_field_ff;
    if (launch_ok) nxt_completion_status_field = 2'h0;
    if (finish) nxt_completion_status_field = completion_status_field_ff | res.completion_status_field;
    if (reset_seq_err) nxt_completion_status_field = completion_status_field_ff | res.completion_status_field;
  end

  always_comb begin
    nxt_div     = div_ff;
    nxt_divld   = divld_ff;
    nxt_divlck  = divlck_ff;
    nxt_lckmode = lckmode_ff;
    if (wr_div & ~divlck_ff) begin
      nxt_div   = bus.wdata[`FCSC_DIV_MSB:0];
      nxt_divld = 1'b1;
    end
    if (lock_now) nxt_divlck = 1'b1;
    if (wr_div & divlck_ff & lckmode_ff & ~bus.wdata[`FCSC_BIT_DIVLCK]) nxt_divlck = 1'b0;
    if (wr_ctl) nxt_lckmode = bus.wdata[`FCSC_BIT_LCKMODE];
    nxt_errstat = err_upd;
    nxt_mask    = wr_mask ? bus.wdata[3:0] : mask_ff;
    nxt_irqstat = irq_upd;
  end

  // Prescale of tick period by (divider + 1) bus cycles; 1 MHz with a divider of 24 and a 40 ns clock
  always_comb begin
    nxt_tick = 1'b0;
    nxt_pre  = pre_ff - 6'h01;
    if (pre_ff == 6'h00) begin
      nxt_pre  = div_ff;
      nxt_tick = divld_ff;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel_stat) begin
      nxt_rdata[`FCSC_BIT_COMMAND_COMPLETE_FLAG]   = command_complete_flag_ff;
      nxt_rdata[`FCSC_BIT_ACCESS_ERROR_FLAG] = access_error_flag_ff;
      nxt_rdata[`FCSC_BIT_PVIOL]  = pviol_ff;
      nxt_rdata[`FCSC_BIT_BUSY]   = busy;
      nxt_rdata[1:0]              = completion_status_field_ff;
    end else if (sel_div) begin
      nxt_rdata = rd_div;
    end else if (sel_err) begin
      nxt_rdata = rd_err;
    end else if (sel_mask) begin
      nxt_rdata = rd_mask;
    end else if (sel_ctl) begin
      nxt_rdata = rd_ctl;
    end
  end

  // One short process per register keeps each reset value in view
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FCSC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Idle after reset: completion flag reads one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_complete_flag_ff <= 1'b1;
    end else begin
      command_complete_flag_ff <= nxt_command_complete_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag_ff <= 1'b0;
    end else begin
      access_error_flag_ff <= nxt_access_error_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pviol_ff <= 1'b0;
    end else begin
      pviol_ff <= nxt_pviol;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_status_field_ff <= 2'h0;
    end else begin
      completion_status_field_ff <= nxt_completion_status_field;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_ff <= 1'b0;
    end else begin
      launch_ff <= nxt_launch;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= `FCSC_RST_DIV;
    end else begin
      div_ff <= nxt_div;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divld_ff <= 1'b0;
    end else begin
      divld_ff <= nxt_divld;
    end
  end

  // Lock survives everything but reset unless override mode is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divlck_ff <= 1'b0;
    end else begin
      divlck_ff <= nxt_divlck;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lckmode_ff <= 1'b0;
    end else begin
      lckmode_ff <= nxt_lckmode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errstat_ff <= 2'h0;
    end else begin
      errstat_ff <= nxt_errstat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `FCSC_RST_MASK;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqstat_ff <= 4'h0;
    end else begin
      irqstat_ff <= nxt_irqstat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 6'h00;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // Tick stays quiet until software has loaded a divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= rd_capture ? nxt_rdata : rdata_ff;
    end
  end

endmodule : fcsc_core

// ### hdl/fcsc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FCSC_DEFINES_SVH
`define FCSC_DEFINES_SVH
`define FCSC_OFF_STATUS    12'h000
`define FCSC_OFF_CLKDIV    12'h004
`define FCSC_OFF_ERRSTAT   12'h008
`define FCSC_OFF_IRQMASK   12'h00c
`define FCSC_OFF_CMDCTL    12'h010
`define FCSC_BIT_COMMAND_COMPLETE_FLAG      7
`define FCSC_BIT_ACCESS_ERROR_FLAG    5
`define FCSC_BIT_PVIOL     4
`define FCSC_BIT_BUSY      3
`define FCSC_BIT_DIVLD     7
`define FCSC_BIT_DIVLCK    6
`define FCSC_DIV_MSB       5
`define FCSC_BIT_LCKMODE   0
`define FCSC_ERR_SINGLE    0
`define FCSC_ERR_DOUBLE    1
`define FCSC_IRQ_COMMAND_COMPLETE_FLAG      0
`define FCSC_IRQ_ACCESS_ERROR_FLAG    1
`define FCSC_IRQ_PVIOL     2
`define FCSC_IRQ_ERR       3
`define FCSC_RST_DIV       6'h00
`define FCSC_RST_MASK      4'h0
`define FCSC_TICK_NS       1000
`define FCSC_CLK_NS        40
`define FCSC_TICK_CYC      ((`FCSC_TICK_NS) / (`FCSC_CLK_NS))
`endif

// ### hdl/fcsc_pkg.sv
// Types shared by the command status and clock divider block
package fcsc_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
    logic        access;
  } fcsc_bus_t;
  typedef struct packed {
    logic       done;
    logic       viol;
    logic [1:0] completion_status_field;
  } fcsc_result_t;
  typedef enum logic [1:0] {FCSC_IDLE, FCSC_RUN, FCSC_DONE} fcsc_state_t;
endpackage : fcsc_pkg

// ### verification/fcsc_core_properties.sv
// Port assertions for the status and divider block
`timescale 1ns/1ps
module fcsc_core_properties
  import fcsc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        seq_violation,
  input wire logic        illegal_cmd,
  input wire logic        protect_hit,
  input wire logic        cmd_launch,
  input wire logic        seq_allowed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_st = psel & penable & pwrite & (paddr == 12'h000);
  wire logic go    = wr_st & pwdata[7] & seq_allowed;
  launch_go_a: assert property (go |=> cmd_launch) else $error("launch missing");
  launch_cause_a: assert property (cmd_launch |-> $past(go))
    else $error("launch without cause");
  busy_after_a: assert property (cmd_launch |-> !seq_allowed) else $error("idle at launch");
  one_shot_a: assert property (cmd_launch |=> !cmd_launch) else $error("launch too long");
  err_block_a: assert property (seq_violation || illegal_cmd |-> ##1 !seq_allowed)
    else $error("access error not set");
  prot_block_a: assert property ($rose(protect_hit) |=> !seq_allowed)
    else $error("protection error not set");
  idle_keep_a: assert property (seq_allowed && !wr_st && !seq_violation && !illegal_cmd
    && !protect_hit |=> seq_allowed) else $error("idle lost");
  status_read_a: assert property (psel && penable && !pwrite && paddr == 12'h000
    |-> !prdata[2] && prdata[3] != prdata[7]) else $error("status bits wrong");
endmodule : fcsc_core_properties
bind fcsc_core fcsc_core_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .seq_violation(seq_violation), .illegal_cmd(illegal_cmd), .protect_hit(protect_hit),
  .cmd_launch(cmd_launch), .seq_allowed(seq_allowed));

// ### verification/tb_fcsc_core.sv
// Self-checking bench for the status and divider block
`timescale 1ns/1ps
module tb_fcsc_core
  import fcsc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        cmd_launch, seq_allowed, div_tick, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ev, f;
  logic [1:0]  mg, m;
  logic [5:0]  v;
  int          err_count, checks_done, cyc, seed, n;
  fcsc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_violation(ev[7]), .illegal_cmd(ev[6]), .protect_hit(ev[5]),
    .seq_start(1'b0), .cmd_done(ev[4]), .cmd_abort(ev[3]), .completion_status_field_err(mg),
    .reset_seq_err(ev[2]), .ecc_single(ev[1]), .ecc_double(ev[0]),
    .cmd_launch(cmd_launch), .seq_allowed(seq_allowed), .div_tick(div_tick), .irq(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task ap(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : ap
  task rdc(input logic [11:0] a, input logic [7:0] e);
    ap(a, 1'b0, 8'h00);
    chk(rd, {24'h000000, e});
  endtask : rdc
  task pl(input logic [7:0] m8);
    @(posedge pclk);
    ev <= m8;
    @(posedge pclk);
    ev <= 8'h00;
  endtask : pl
  // Irq is combinational from registers, so let the write land first
  task ic(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ic
  task tk(input logic [5:0] d);
    n = 0;
    @(posedge pclk iff div_tick === 1'b1);
    do begin
      @(posedge pclk);
      n++;
    end while (div_tick !== 1'b1);
    chk(n, {26'h0, d} + 32'h1);
  endtask : tk
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, mg} = '0;
    seed = 84;
    m = 2'($random(seed));
    v = 6'($random(seed)) & 6'h07;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 8'h80);
    rdc(12'h004, 8'h00);
    rdc(12'h020, 8'h00);
    chk({31'h0, se}, 32'h1);
    $display("test reset done");
    ap(12'h000, 1'b1, 8'h80);
    rdc(12'h000, 8'h08);
    ap(12'h000, 1'b1, 8'hb0);
    rdc(12'h000, 8'h08);
    mg <= m;
    pl(8'h10);
    mg <= 2'b00;
    rdc(12'h000, 8'h80 | m);
    for (int i = 0; i < 3; i++) begin
      f = (i == 2) ? 8'h10 : 8'h20;
      pl(8'h80 >> i);
      rdc(12'h000, 8'h80 | f | m);
      ap(12'h000, 1'b1, 8'h80);
      rdc(12'h000, 8'h80 | f | m);
      ap(12'h000, 1'b1, 8'h00);
      rdc(12'h000, 8'h80 | f | m);
      ap(12'h000, 1'b1, f);
      rdc(12'h000, 8'h80 | m);
    end
    mg <= 2'b10;
    pl(8'h04);
    mg <= 2'b00;
    rdc(12'h000, 8'h82 | m);
    ap(12'h000, 1'b1, 8'h80);
    pl(8'h08);
    rdc(12'h000, 8'h80);
    $display("test status done");
    pl(8'h03);
    rdc(12'h008, 8'h03);
    ap(12'h008, 1'b1, 8'h00);
    rdc(12'h008, 8'h03);
    ap(12'h008, 1'b1, 8'h01);
    rdc(12'h008, 8'h02);
    ap(12'h010, 1'b1, 8'hf0);
    ap(12'h00c, 1'b1, 8'h01);
    ic(1'b0);
    ap(12'h000, 1'b1, 8'h80);
    pl(8'h10);
    ic(1'b1);
    ap(12'h00c, 1'b1, 8'h00);
    ic(1'b0);
    ap(12'h00c, 1'b1, 8'h01);
    ic(1'b1);
    ap(12'h010, 1'b1, 8'h10);
    ic(1'b0);
    $display("test errors and irq done");
    ap(12'h004, 1'b1, 8'h18);
    rdc(12'h004, 8'h98);
    tk(6'h18);
    ap(12'h004, 1'b1, {2'b00, v});
    rdc(12'h004, {2'b10, v});
    tk(v);
    ap(12'h004, 1'b1, {2'b01, v});
    rdc(12'h004, {2'b11, v});
    ap(12'h004, 1'b1, {2'b00, v ^ 6'h01});
    rdc(12'h004, {2'b11, v});
    tk(v);
    $display("test divider done");
    wrap_up();
  end
endmodule : tb_fcsc_core
